// ===== shared/cc_detect_defines.vh
// Constants for the Type-C channel attach and detach detector.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef CC_DETECT_DEFINES_VH
`define CC_DETECT_DEFINES_VH

`define CLK_PERIOD_NS 8
// Detach debounce time in microseconds
`define DEBOUNCE_TIME_US 150
// Sized to the timer: 150 us at 8 ns a cycle is 18750
`define DEBOUNCE_CYCLES 16'h493e
// Attach debounce time in microseconds
`define ATTACH_TIME_US 150
// Sized to the timer: 150 us at 8 ns a cycle is 18750
`define ATTACH_CYCLES 16'h493e
// VCONN fast shutdown time in nanoseconds
// Two sync stages plus the output register take three cycles
`define CABLE_FAST_SHUTDOWN_TIME_NS 32
`define CABLE_FAST_SHUTDOWN_CYCLES (`CABLE_FAST_SHUTDOWN_TIME_NS / `CLK_PERIOD_NS)

// Pull-up advertisement levels
`define PULLUP_1P5A 1'h0
`define PULLUP_3P0A 1'h1

// Reference select codes
`define REF_SEL_SNK 2'h0
`define REF_SEL_SRC_1P5 2'h1
`define REF_SEL_SRC_3P0 2'h2

// Connection state codes
`define CONN_NONE 3'h0
`define CONN_SINK 3'h1
`define CONN_CABLE 3'h2
`define CONN_CABLE_SINK 3'h3
`define CONN_SOURCE 3'h4

// Advertised source current codes in sink mode
`define ADV_NONE 2'h0
`define ADV_DEFAULT 2'h1
`define ADV_1P5A 2'h2
`define ADV_3P0A 2'h3

`define TIMER_WIDTH 16

`endif

// ===== src/cc_pin_sync.v
// Two-stage synchroniser for one bundle of comparator levels.
// Assumes inputs are asynchronous to clk; output is clean on clk.
`timescale 1ns/10ps
`default_nettype none

module cc_pin_sync #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Levels
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always @(posedge clk) begin
		if (rst) begin
			meta_q <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ===== src/typec_cc_attach_detect.v
// Per-port Type-C channel attach, orientation and detach detector.
// Assumes analog comparators per pin that report below-cable, below-
// attach and above-disconnect levels against the selected references,
// plus bus power present and an overvoltage flag.
`timescale 1ns/10ps
`default_nettype none
`include "cc_detect_defines.vh"

module typec_cc_attach_detect #(
	parameter [`TIMER_WIDTH-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
	parameter [`TIMER_WIDTH-1:0] ATTACH_CYCLES = `ATTACH_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Configuration from firmware
	input wire source_mode,
	input wire regulator_at_5v,
	input wire want_3p0a,
	// Comparators, pin one
	input wire pin_one_below_cable,
	input wire pin_one_below_attach,
	input wire pin_one_above_disc,
	// Comparators, pin two
	input wire pin_two_below_cable,
	input wire pin_two_below_attach,
	input wire pin_two_above_disc,
	// Sink-side level comparators (source pull-up level decode)
	input wire pin_one_above_1p5,
	input wire pin_one_above_3p0,
	input wire pin_two_above_1p5,
	input wire pin_two_above_3p0,
	// Bus power present and protection
	input wire bus_power_present,
	input wire cc_overvoltage,
	// Analog controls
	output reg [1:0] detect_reference_node,
	output reg pullup_enable,
	output reg pullup_level,
	output reg sink_pulldown_enable,
	// Power actions
	output reg port_bus_power_output,
	output reg vconn_on_pin_one,
	output reg vconn_on_pin_two,
	output reg pd_tx_disable,
	// Status
	output reg [2:0] connection_state,
	output reg orientation,
	output reg watch_pin_one,
	output reg watch_pin_two,
	output reg [1:0] advertised_current
);

	// ==========================================================
	// Input synchronisation
	wire [11:0] raw_in;
	wire [11:0] sync_in;
	assign raw_in = {pin_one_below_cable, pin_one_below_attach,
		pin_one_above_disc, pin_two_below_cable, pin_two_below_attach,
		pin_two_above_disc, pin_one_above_1p5, pin_one_above_3p0,
		pin_two_above_1p5, pin_two_above_3p0, bus_power_present,
		cc_overvoltage};

	cc_pin_sync #(.WIDTH(12)) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in(raw_in),
		.sync_out(sync_in)
	);

	wire c1_cable = sync_in[11];
	wire c1_att = sync_in[10];
	wire c1_disc = sync_in[9];
	wire c2_cable = sync_in[8];
	wire c2_att = sync_in[7];
	wire c2_disc = sync_in[6];
	wire c1_1p5 = sync_in[5];
	wire c1_3p0 = sync_in[4];
	wire c2_1p5 = sync_in[3];
	wire c2_3p0 = sync_in[2];
	wire vbus_s = sync_in[1];
	wire ovp_s = sync_in[0];

	// Pin classes: cable pull-down below cable level, sink between
	wire c1_is_cable = c1_cable;
	wire c2_is_cable = c2_cable;
	wire c1_is_sink = c1_att & ~c1_cable;
	wire c2_is_sink = c2_att & ~c2_cable;

	// ==========================================================
	// State machine
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_SINK_ATT = 6'h02;
	localparam [5:0] S_CABLE = 6'h04;
	localparam [5:0] S_CABLE_SINK = 6'h08;
	localparam [5:0] S_SNK_WAIT = 6'h10;
	localparam [5:0] S_SNK_ATT = 6'h20;

	reg [5:0] state_q;
	reg [5:0] state_d;
	reg orient_q;
	reg orient_d;
	reg [`TIMER_WIDTH-1:0] timer_q;
	reg [`TIMER_WIDTH-1:0] timer_d;
	reg level_q;
	reg ovp_q;

	// Pattern seen on the pins as a source; any one of the three keeps the attach debounce counting
	wire pat_sink = c1_is_sink ^ c2_is_sink;
	wire pat_cable_only = (c1_is_cable & ~c2_att) | (c2_is_cable & ~c1_att);
	wire pat_cable_sink = (c1_is_cable & c2_is_sink) |
		(c2_is_cable & c1_is_sink);
	// Watched pin above disconnect (orient 0 means pin one watched)
	wire watched_disc = orient_q ? c2_disc : c1_disc;
	wire cable_gone = orient_q ? ~c2_cable : ~c1_cable;
	wire other_sink = orient_q ? c1_is_sink : c2_is_sink;

	always @* begin
		state_d = state_q;
		orient_d = orient_q;
		timer_d = timer_q;
		case (state_q)
		S_IDLE: begin
			// Keep watching both pins; nothing powered
			if (!source_mode) begin
				state_d = S_SNK_WAIT;
				timer_d = {`TIMER_WIDTH{1'b0}};
			end else if (pat_cable_sink | pat_sink | pat_cable_only) begin
				if (timer_q >= ATTACH_CYCLES) begin
					timer_d = {`TIMER_WIDTH{1'b0}};
					if (pat_cable_sink) begin
						state_d = S_CABLE_SINK;
						orient_d = c1_is_cable; // watch sink pin
					end else if (pat_sink) begin
						state_d = S_SINK_ATT;
						orient_d = c2_is_sink;
					end else begin
						state_d = S_CABLE;
						orient_d = c2_is_cable;
					end
				end else begin
					timer_d = timer_q + 1'b1;
				end
			end else begin
				timer_d = {`TIMER_WIDTH{1'b0}};
			end
		end
		S_SINK_ATT, S_CABLE_SINK: begin
			if (!source_mode) begin
				state_d = S_IDLE;
				timer_d = {`TIMER_WIDTH{1'b0}};
			end else if (watched_disc) begin
				if (timer_q >= DEBOUNCE_CYCLES) begin
					state_d = S_IDLE;
					timer_d = {`TIMER_WIDTH{1'b0}};
				end else begin
					timer_d = timer_q + 1'b1;
				end
			end else begin
				timer_d = {`TIMER_WIDTH{1'b0}};
			end
		end
		S_CABLE: begin
			// Cable pin watched for detach, other pin for a sink
			timer_d = {`TIMER_WIDTH{1'b0}};
			if (!source_mode || cable_gone) begin
				state_d = S_IDLE;
			end else if (other_sink) begin
				state_d = S_CABLE_SINK;
				orient_d = ~orient_q;
			end
		end
		S_SNK_WAIT: begin
			timer_d = {`TIMER_WIDTH{1'b0}};
			if (source_mode) begin
				state_d = S_IDLE;
			end else if (vbus_s) begin
				state_d = S_SNK_ATT;
				orient_d = c2_1p5 & ~c1_1p5;
			end
		end
		S_SNK_ATT: begin
			timer_d = {`TIMER_WIDTH{1'b0}};
			if (source_mode) begin
				state_d = S_IDLE;
			end else if (!vbus_s) begin
				state_d = S_SNK_WAIT;
			end
		end
		default: begin
			state_d = S_IDLE;
			timer_d = {`TIMER_WIDTH{1'b0}};
		end
		endcase
	end

	// ==========================================================
	// Registers and outputs
	wire src_now = (state_d != S_SNK_WAIT) && (state_d != S_SNK_ATT);
	wire pwr_d = (state_d == S_SINK_ATT) || (state_d == S_CABLE_SINK);
	wire cab_d = (state_d == S_CABLE_SINK);
	wire watch_both_d = (state_d == S_IDLE) || (state_d == S_CABLE);
	wire sel_c1 = orient_d ? c2_1p5 : c1_1p5;
	wire sel_c3 = orient_d ? c2_3p0 : c1_3p0;

	always @(posedge clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			orient_q <= 1'b0;
			timer_q <= {`TIMER_WIDTH{1'b0}};
			level_q <= `PULLUP_1P5A;
			ovp_q <= 1'b0;
			detect_reference_node <= `REF_SEL_SRC_1P5;
			pullup_enable <= 1'b0;
			pullup_level <= `PULLUP_1P5A;
			sink_pulldown_enable <= 1'b0;
			port_bus_power_output <= 1'b0;
			vconn_on_pin_one <= 1'b0;
			vconn_on_pin_two <= 1'b0;
			pd_tx_disable <= 1'b0;
			connection_state <= `CONN_NONE;
			orientation <= 1'b0;
			watch_pin_one <= 1'b0;
			watch_pin_two <= 1'b0;
			advertised_current <= `ADV_NONE;
		end else begin
			state_q <= state_d;
			orient_q <= orient_d;
			timer_q <= timer_d;
			// 3.0 A only once the regulator runs at 5 V
			if (!regulator_at_5v || !pwr_d)
				level_q <= `PULLUP_1P5A;
			else
				level_q <= want_3p0a;
			// Overvoltage latches until the next idle pass
			if (ovp_s)
				ovp_q <= 1'b1;
			else if (state_d == S_IDLE || state_d == S_SNK_WAIT)
				ovp_q <= 1'b0;
			pullup_enable <= src_now;
			pullup_level <= level_q;
			sink_pulldown_enable <= ~src_now;
			if (!src_now)
				detect_reference_node <= `REF_SEL_SNK;
			else if (level_q == `PULLUP_3P0A)
				detect_reference_node <= `REF_SEL_SRC_3P0;
			else
				detect_reference_node <= `REF_SEL_SRC_1P5;
			port_bus_power_output <= pwr_d;
			// Fast path: overvoltage drops VCONN straight from sync
			vconn_on_pin_one <= cab_d & orient_d & ~ovp_s & ~ovp_q;
			vconn_on_pin_two <= cab_d & ~orient_d & ~ovp_s & ~ovp_q;
			pd_tx_disable <= ovp_s | ovp_q;
			case (state_d)
			S_SINK_ATT: connection_state <= `CONN_SINK;
			S_CABLE: connection_state <= `CONN_CABLE;
			S_CABLE_SINK: connection_state <= `CONN_CABLE_SINK;
			S_SNK_ATT: connection_state <= `CONN_SOURCE;
			default: connection_state <= `CONN_NONE;
			endcase
			orientation <= orient_d;
			watch_pin_one <= src_now & (watch_both_d | ~orient_d);
			watch_pin_two <= src_now & (watch_both_d | orient_d);
			if (state_d != S_SNK_ATT)
				advertised_current <= `ADV_NONE;
			else if (sel_c3)
				advertised_current <= `ADV_3P0A;
			else if (sel_c1)
				advertised_current <= `ADV_1P5A;
			else
				advertised_current <= `ADV_DEFAULT;
		end
	end

endmodule

`default_nettype wire

// ===== verif/cc_far_end.sv
// Far-end model: what is plugged into each channel pin, as comparator levels.
// Assumes pin kind codes 0 open, 1 sink pull-down, 2 cable, 3 source pull-up.
`timescale 1ns/10ps
`default_nettype none
module cc_far_end (
	// Plug selection
	input wire logic [1:0] kind_one,
	input wire logic [1:0] kind_two,
	input wire logic adv_3p0,
	// Comparator levels
	output logic pin_one_below_cable,
	output logic pin_one_below_attach,
	output logic pin_one_above_disc,
	output logic pin_one_above_1p5,
	output logic pin_one_above_3p0,
	output logic pin_two_below_cable,
	output logic pin_two_below_attach,
	output logic pin_two_above_disc,
	output logic pin_two_above_1p5,
	output logic pin_two_above_3p0
);
	// Bits: below cable, below attach, above disc, above 1.5, above 3.0
	function automatic logic [4:0] lv(input logic [1:0] k, input logic a);
		case (k)
			2'h0: lv = 5'h04;
			2'h1: lv = 5'h08;
			2'h2: lv = 5'h18;
			default: lv = {4'h3, a};
		endcase
	endfunction
	assign {pin_one_below_cable, pin_one_below_attach, pin_one_above_disc,
		pin_one_above_1p5, pin_one_above_3p0} = lv(kind_one, adv_3p0);
	assign {pin_two_below_cable, pin_two_below_attach, pin_two_above_disc,
		pin_two_above_1p5, pin_two_above_3p0} = lv(kind_two, adv_3p0);
endmodule
`default_nettype wire

// ===== verif/cc_detect_sva.sv
// Checker on the attach detector's ports, bound to every instance.
// Assumes only relations between registered outputs and levels.
`timescale 1ns/10ps
`default_nettype none
module cc_detect_sva (
	// Clock, reset, inputs
	input wire logic clk,
	input wire logic rst,
	input wire logic source_mode,
	input wire logic cc_overvoltage,
	// Outputs
	input wire logic [1:0] detect_reference_node,
	input wire logic pullup_enable,
	input wire logic pullup_level,
	input wire logic port_bus_power_output,
	input wire logic vconn_on_pin_one,
	input wire logic vconn_on_pin_two,
	input wire logic pd_tx_disable,
	input wire logic [2:0] connection_state,
	input wire logic watch_pin_one,
	input wire logic watch_pin_two
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic no_vc = !vconn_on_pin_one && !vconn_on_pin_two;
	wire logic vbus = port_bus_power_output;
	property p_src_ref; (source_mode && $stable(pullup_level)) [*6]
		|-> detect_reference_node == {pullup_level, !pullup_level};
	endproperty
	a_src_ref: assert property (p_src_ref) else $error("source ref");
	property p_snk_ref; (!source_mode) [*6]
		|-> detect_reference_node == 2'h0 && !pullup_enable; endproperty
	a_snk_ref: assert property (p_snk_ref) else $error("sink ref");
	property p_pull; source_mode [*6] |-> pullup_enable; endproperty
	a_pull: assert property (p_pull) else $error("pull-up off");
	property p_idle; source_mode && connection_state == 3'h0
		|-> !vbus && no_vc; endproperty
	a_idle: assert property (p_idle) else $error("idle power");
	property p_sink; connection_state == 3'h1
		|-> vbus && no_vc && (watch_pin_one ^ watch_pin_two); endproperty
	a_sink: assert property (p_sink) else $error("sink state");
	property p_cab; connection_state == 3'h2
		|-> !vbus && no_vc && watch_pin_one && watch_pin_two; endproperty
	a_cab: assert property (p_cab) else $error("cable state");
	property p_cs; connection_state == 3'h3 && !pd_tx_disable |-> vbus &&
		vconn_on_pin_one == watch_pin_two && vconn_on_pin_two == watch_pin_one
		&& watch_pin_one != watch_pin_two; endproperty
	a_cs: assert property (p_cs) else $error("cable sink");
	property p_ovp; $rose(cc_overvoltage) ##1 cc_overvoltage [*2]
		|=> no_vc && pd_tx_disable; endproperty
	a_ovp: assert property (p_ovp) else $error("vconn not shut");
	c_sink: cover property (connection_state == 3'h1);
	c_cs: cover property (connection_state == 3'h3);
	c_ovp: cover property ($rose(pd_tx_disable));
	c_snk: cover property (connection_state == 3'h4);
endmodule
bind typec_cc_attach_detect cc_detect_sva cc_detect_sva_i (.clk(clk),
	.rst(rst), .source_mode(source_mode), .cc_overvoltage(cc_overvoltage),
	.detect_reference_node(detect_reference_node),
	.pullup_enable(pullup_enable), .pullup_level(pullup_level),
	.port_bus_power_output(port_bus_power_output),
	.vconn_on_pin_one(vconn_on_pin_one), .vconn_on_pin_two(vconn_on_pin_two),
	.pd_tx_disable(pd_tx_disable), .connection_state(connection_state),
	.watch_pin_one(watch_pin_one), .watch_pin_two(watch_pin_two));
`default_nettype wire

// ===== verif/typec_cc_attach_detect_test.sv
// Self-checking bench for the attach detector with the far-end model.
// Assumes debounce counts shortened to 8 cycles.
`timescale 1ns/10ps
`default_nettype none
module typec_cc_attach_detect_test;
	logic clk, rst, source_mode, regulator_at_5v, want_3p0a;
	logic bus_power_present, cc_overvoltage, adv_3p0;
	logic [1:0] kind_one, kind_two;
	wire logic c1c, c1a, c1d, c115, c130, c2c, c2a, c2d, c215, c230;
	wire logic [1:0] ref_sel, adv_cur;
	wire logic [2:0] state;
	wire logic pu_en, pu_lvl, pd_en, vbus, vc1, vc2, tx_off, orient, w1, w2;
	int miscompares = 0;
	int n_compared = 0;
	cc_far_end cc_far_end_i (.kind_one(kind_one), .kind_two(kind_two),
		.adv_3p0(adv_3p0), .pin_one_below_cable(c1c),
		.pin_one_below_attach(c1a), .pin_one_above_disc(c1d),
		.pin_one_above_1p5(c115), .pin_one_above_3p0(c130),
		.pin_two_below_cable(c2c), .pin_two_below_attach(c2a),
		.pin_two_above_disc(c2d), .pin_two_above_1p5(c215),
		.pin_two_above_3p0(c230));
	typec_cc_attach_detect #(.DEBOUNCE_CYCLES(16'h8), .ATTACH_CYCLES(16'h8))
		typec_cc_attach_detect_i (.clk(clk), .rst(rst),
		.source_mode(source_mode), .regulator_at_5v(regulator_at_5v),
		.want_3p0a(want_3p0a), .pin_one_below_cable(c1c),
		.pin_one_below_attach(c1a), .pin_one_above_disc(c1d),
		.pin_two_below_cable(c2c), .pin_two_below_attach(c2a),
		.pin_two_above_disc(c2d), .pin_one_above_1p5(c115),
		.pin_one_above_3p0(c130), .pin_two_above_1p5(c215),
		.pin_two_above_3p0(c230), .bus_power_present(bus_power_present),
		.cc_overvoltage(cc_overvoltage), .detect_reference_node(ref_sel),
		.pullup_enable(pu_en), .pullup_level(pu_lvl),
		.sink_pulldown_enable(pd_en), .port_bus_power_output(vbus),
		.vconn_on_pin_one(vc1), .vconn_on_pin_two(vc2),
		.pd_tx_disable(tx_off), .connection_state(state),
		.orientation(orient), .watch_pin_one(w1), .watch_pin_two(w2),
		.advertised_current(adv_cur));
	task check(input string nm, input logic [2:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wait_state(input logic [2:0] s);
		int k;
		k = 0;
		while (state !== s && k < 60) begin
			step(1);
			k++;
		end
		check("state", state, s);
	endtask
	task sink_one;
		kind_one = 2'h1;
		wait_state(3'h1);
		check("power", {vbus, vc1, vc2}, 3'h4);
		check("watch", {1'b0, w1, w2}, 3'h2);
		check("pulls", {pu_en, pu_lvl, pd_en}, 3'h4);
		want_3p0a = 1;
		step(10);
		check("level", {2'h0, pu_lvl}, 3'h0);
		regulator_at_5v = 1;
		step(10);
		check("level", {2'h0, pu_lvl}, 3'h1);
		check("ref", {1'b0, ref_sel}, 3'h2);
		want_3p0a = 0;
		kind_one = 2'h0;
		step(5);
		kind_one = 2'h1;
		step(20);
		check("glitch", state, 3'h1);
		kind_one = 2'h0;
		wait_state(3'h0);
		check("off", {vbus, w1, w2}, 3'h3);
	endtask
	task cable_sink;
		kind_two = 2'h2;
		wait_state(3'h2);
		check("power", {vbus, vc1, vc2}, 3'h0);
		check("orient", {2'h0, orient}, 3'h1);
		check("watch", {1'b0, w1, w2}, 3'h3);
		kind_one = 2'h1;
		wait_state(3'h3);
		check("power", {vbus, vc1, vc2}, 3'h5);
		check("watch", {1'b0, w1, w2}, 3'h2);
		check("orient", {2'h0, orient}, 3'h0);
		kind_two = 2'h0;
		step(20);
		check("ignore", state, 3'h3);
		cc_overvoltage = 1;
		step(4);
		check("ovp", {vc1, vc2, tx_off}, 3'h1);
		cc_overvoltage = 0;
		kind_one = 2'h0;
		wait_state(3'h0);
	endtask
	task sink_mode;
		source_mode = 0;
		kind_one = 2'h3;
		adv_3p0 = 1;
		step(10);
		check("ref", {1'b0, ref_sel}, 3'h0);
		check("pulls", {pu_en, pu_lvl, pd_en}, 3'h1);
		check("novbus", state, 3'h0);
		bus_power_present = 1;
		wait_state(3'h4);
		check("adv", {1'b0, adv_cur}, 3'h3);
		adv_3p0 = 0;
		step(5);
		check("adv", {1'b0, adv_cur}, 3'h2);
		check("pulls", {pu_en, pu_lvl, pd_en}, 3'h1);
		bus_power_present = 0;
		wait_state(3'h0);
		check("ref", {1'b0, ref_sel}, 3'h0);
	endtask
	task complete_run;
		$display("compared %0d miscompared %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst, source_mode} = 2'h3;
		{regulator_at_5v, want_3p0a, bus_power_present} = 3'h0;
		{cc_overvoltage, adv_3p0, kind_one, kind_two} = 6'h00;
		repeat (4) @(posedge clk);
		#1 rst = 0;
		step(2);
		sink_one;
		regulator_at_5v = 0;
		cable_sink;
		sink_mode;
		complete_run;
	end
	// Generous bound: the three scenarios need well under 1000 cycles
	initial begin
		#40000;
		miscompares++;
		complete_run;
	end
endmodule
`default_nettype wire
